// ==== verilog/pecs_pkg.sv ====
package pecs_pkg;

  // -----------------------------------------------------------------
  // Register numbers and APB byte addresses
  // -----------------------------------------------------------------
  localparam logic [4:0]  PECS_IDX_BASIC     = 5'h00;   // Basic control, holds the reset bit.
  localparam logic [4:0]  PECS_IDX_EXT       = 5'h16;   // Extended control and status.
  localparam logic [11:0] PECS_ADDR_IRQ_STAT = 12'h080; // Sticky event status, read only.
  localparam logic [11:0] PECS_ADDR_IRQ_CLR  = 12'h084; // Write one to clear, write only.
  localparam logic [11:0] PECS_ADDR_IRQ_EN   = 12'h088; // Interrupt enable.

  // -----------------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------------
  localparam int PECS_BIT_SWRST  = 15; // Software reset in basic control.
  localparam int PECS_BIT_BYPASS = 15;
  localparam int PECS_BIT_SQE    = 13;
  localparam int PECS_BIT_SQL    = 10; // Low bit of the two-bit squelch field.
  localparam int PECS_BIT_STKEN  = 9;
  localparam int PECS_BIT_EOF    = 8;
  localparam int PECS_BIT_DISC   = 7;
  localparam int PECS_BIT_LINK   = 6;
  localparam int PECS_BIT_BCAST  = 0;
  localparam int PECS_IRQ_EOF    = 0; // Event bits of the interrupt registers.
  localparam int PECS_IRQ_DISC   = 1;

  // -----------------------------------------------------------------
  // Types and values after reset
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    PECS_SQL_NORMAL = 2'b00,
    PECS_SQL_LOW    = 2'b01,
    PECS_SQL_HIGH   = 2'b10,
    PECS_SQL_RSVD   = 2'b11
  } pecs_sql_e;

  localparam logic      PECS_RST_BYPASS = 1'b0;
  localparam logic      PECS_RST_SQE    = 1'b1;
  localparam pecs_sql_e PECS_RST_SQL    = PECS_SQL_NORMAL;
  localparam logic      PECS_RST_STKEN  = 1'b1;
  localparam logic      PECS_RST_BCAST  = 1'b0;
  localparam logic [1:0] PECS_RST_IRQ   = 2'h0;

endpackage

// ==== verilog/pecs_ext_ctrl.sv ====
// Operation
// - Bypass bit set forces link pass, skipping the link integrity machine.
// - Squelch field picks normal, lowered or raised 10BASE-T receive threshold.
// - Squelch field is read/write sticky; code 11 is reserved, never programmed.
// - Sticky-reset-enable set: sticky bits keep values across software reset.
// - Sticky-reset-enable clear: software reset returns sticky bits to defaults.
// - Super-sticky bits survive software reset whatever the enable says.
// - Sticky-reset-enable is itself read/write super-sticky.
// - Broadcast enabled: every management write is copied to all PHYs.
// - Broadcast cleared: writes reach only the addressed PHY again.
// - Reads under broadcast still return only the addressed PHY contents.
// - Broadcast enable is read/write sticky, default zero.
// - End-of-frame error sets a read-only self-clearing flag, default zero.
// - 10BASE-T disconnect sets a read-only self-clearing flag, default zero.
// - Read-only bit shows one while the 10BASE-T link is active.
// - Sticky control bit set disables the 10BASE-T SQE test.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module pecs_ext_ctrl
  import pecs_pkg::*;
(
  input  wire logic        clk_sys,     // 250 MHz system clock.
  input  wire logic        rstn,        // Asynchronous hardware reset, active low.
  input  wire logic        psel,        // APB select.
  input  wire logic        penable,     // APB access phase.
  input  wire logic        pwrite,      // APB direction, high for write.
  input  wire logic [11:0] paddr,       // APB byte address.
  input  wire logic [31:0] pwdata,      // APB write data.
  output logic      [31:0] prdata,      // APB read data, registered.
  output logic             pready,      // APB ready.
  output logic             pslverr,     // APB error on unmapped address.
  input  wire logic        bc_in_valid, // Broadcast write from a sibling PHY.
  input  wire logic [4:0]  bc_in_reg,   // Its register number.
  input  wire logic [15:0] bc_in_data,  // Its data.
  output logic             bc_wr_valid, // Broadcast write to sibling PHYs.
  output logic      [4:0]  bc_wr_reg,   // Register number of that write.
  output logic      [15:0] bc_wr_data,  // Data of that write.
  input  wire logic        lism_pass,   // Link integrity machine result.
  input  wire logic        tenbt_link,  // Live 10BASE-T link indicator.
  input  wire logic        eof_err,     // End-of-frame error event pulse.
  input  wire logic        tenbt_disc,  // 10BASE-T disconnect event pulse.
  output logic             link_pass,   // Link pass status to the port.
  output logic      [1:0]  squelch_sel, // Receive squelch threshold select.
  output logic             sqe_off,     // SQE test disabled.
  output logic             soft_reset,  // Software reset pulse to the port.
  output logic             irq          // Level interrupt.
);

  // ---------------------------------------------------------------
  // Address decoding helpers
  // ---------------------------------------------------------------

  // True when the address falls in the management register space.
  function automatic logic is_mgmt(input logic [11:0] a);
    is_mgmt = (a[11:7] == 5'h00) && (a[1:0] == 2'b00);
  endfunction

  // Register number held by a management-space address.
  function automatic logic [4:0] reg_of(input logic [11:0] a);
    reg_of = a[6:2];
  endfunction

  // ---------------------------------------------------------------
  // Control and status state
  // ---------------------------------------------------------------
  logic            bypass;
  pecs_sql_e       squelch;
  logic            sqe_dis;
  logic            stky_en;
  logic            bcast_en;
  logic            eof_flag;
  logic            disc_flag;
  logic      [1:0] irq_stat;
  logic      [1:0] irq_en;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic            acc;
  logic            setup;
  logic            hit;
  logic            apb_wr;
  logic            apb_rd;
  logic            eff_wr;
  logic      [4:0] eff_reg;
  logic     [15:0] eff_data;
  logic            wr_ext;
  logic            rd_ext;
  logic            swrst;
  logic     [31:0] next_rdata;

  // Zero-wait slave: read data is captured in the setup cycle, writes act in the access cycle.
  assign acc     = psel & penable;
  assign setup   = psel & ~penable;
  assign hit     = is_mgmt(paddr) || (paddr == PECS_ADDR_IRQ_STAT)
                   || (paddr == PECS_ADDR_IRQ_CLR) || (paddr == PECS_ADDR_IRQ_EN);
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign apb_wr  = acc & pwrite & hit;
  assign apb_rd  = acc & ~pwrite & hit;

  // Local writes win over a sibling's broadcast in the same cycle.
  assign eff_wr   = (apb_wr & is_mgmt(paddr)) | bc_in_valid;
  assign eff_reg  = (apb_wr & is_mgmt(paddr)) ? reg_of(paddr) : bc_in_reg;
  assign eff_data = (apb_wr & is_mgmt(paddr)) ? pwdata[15:0] : bc_in_data;
  assign wr_ext   = eff_wr && (eff_reg == PECS_IDX_EXT);
  assign swrst    = eff_wr && (eff_reg == PECS_IDX_BASIC)
                    && eff_data[PECS_BIT_SWRST];
  assign rd_ext   = apb_rd && is_mgmt(paddr) && (reg_of(paddr) == PECS_IDX_EXT);

  // Read mux; only this PHY's own state is ever returned.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (is_mgmt(paddr) && (reg_of(paddr) == PECS_IDX_EXT)) begin
      next_rdata[PECS_BIT_BYPASS]         = bypass;
      next_rdata[PECS_BIT_SQE]            = sqe_dis;
      next_rdata[PECS_BIT_SQL+1:PECS_BIT_SQL] = squelch;
      next_rdata[PECS_BIT_STKEN]          = stky_en;
      next_rdata[PECS_BIT_EOF]            = eof_flag;
      next_rdata[PECS_BIT_DISC]           = disc_flag;
      next_rdata[PECS_BIT_LINK]           = tenbt_link;
      next_rdata[PECS_BIT_BCAST]          = bcast_en;
    end else if (paddr == PECS_ADDR_IRQ_STAT) begin
      next_rdata[1:0] = irq_stat;
    end else if (paddr == PECS_ADDR_IRQ_EN) begin
      next_rdata[1:0] = irq_en;
    end
  end

  // Read data register, loaded in the setup cycle.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= next_rdata;
    end
  end

  // The live link bit reaches the read data as it stood in the setup cycle.
  a_link_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    setup && is_mgmt(paddr) && (reg_of(paddr) == PECS_IDX_EXT)
    |=> (prdata[PECS_BIT_LINK] == $past(tenbt_link)))
    else $error("Read data did not carry the live link bit.");

  // ---------------------------------------------------------------
  // Sticky controls
  // ---------------------------------------------------------------

  // Sticky bits fall back to defaults on software reset unless kept.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bypass   <= PECS_RST_BYPASS;
      squelch  <= PECS_RST_SQL;
      sqe_dis  <= PECS_RST_SQE;
      bcast_en <= PECS_RST_BCAST;
    end else if (swrst && !stky_en) begin
      bypass   <= PECS_RST_BYPASS;
      squelch  <= PECS_RST_SQL;
      sqe_dis  <= PECS_RST_SQE;
      bcast_en <= PECS_RST_BCAST;
    end else if (wr_ext) begin
      bypass   <= eff_data[PECS_BIT_BYPASS];
      sqe_dis  <= eff_data[PECS_BIT_SQE];
      bcast_en <= eff_data[PECS_BIT_BCAST];
      // The reserved squelch code is refused and the old choice stands.
      if (eff_data[PECS_BIT_SQL+1:PECS_BIT_SQL] != PECS_SQL_RSVD) begin
        squelch <= pecs_sql_e'(eff_data[PECS_BIT_SQL+1:PECS_BIT_SQL]);
      end
    end
  end

  // A write to the extended register always lands in the SQE disable and broadcast enable bits.
  a_sqe_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_ext
    |=> (sqe_dis == $past(eff_data[PECS_BIT_SQE])))
    else $error("SQE disable bit did not take the written value.");

  a_bcast_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_ext
    |=> (bcast_en == $past(eff_data[PECS_BIT_BCAST])))
    else $error("Broadcast enable did not take the written value.");

  // Super-sticky enable: only hardware reset or a write changes it.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stky_en <= PECS_RST_STKEN;
    end else if (wr_ext) begin
      stky_en <= eff_data[PECS_BIT_STKEN];
    end
  end

  // The super-sticky enable is still an ordinary read/write bit.
  a_stky_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_ext
    |=> (stky_en == $past(eff_data[PECS_BIT_STKEN])))
    else $error("Sticky reset enable did not take the written value.");

  // ---------------------------------------------------------------
  // Port-facing outputs
  // ---------------------------------------------------------------

  // Registered controls toward the media logic.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      link_pass   <= 1'b0;
      squelch_sel <= PECS_RST_SQL;
      sqe_off     <= PECS_RST_SQE;
      soft_reset  <= 1'b0;
    end else begin
      link_pass   <= bypass | lism_pass;
      squelch_sel <= squelch;
      sqe_off     <= sqe_dis;
      soft_reset  <= swrst;
    end
  end

  // The media logic never sees the reserved squelch code, and every reset write pulses.
  a_squelch_legal: assert property (@(posedge clk_sys) disable iff (!rstn)
    squelch_sel != PECS_SQL_RSVD)
    else $error("Reserved squelch code reached the receiver.");

  a_srst_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
    swrst |=> soft_reset)
    else $error("Software reset write gave no reset pulse.");

  // Local management-space writes are repeated to the siblings while broadcast is on.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bc_wr_valid <= 1'b0;
      bc_wr_reg   <= 5'h00;
      bc_wr_data  <= 16'h0000;
    end else begin
      bc_wr_valid <= apb_wr & is_mgmt(paddr) & bcast_en;
      if (apb_wr & is_mgmt(paddr)) begin
        bc_wr_reg  <= reg_of(paddr);
        bc_wr_data <= pwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Self-clearing flags
  // ---------------------------------------------------------------

  // A read clears the flags, but an event in that cycle wins.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      eof_flag  <= 1'b0;
      disc_flag <= 1'b0;
    end else begin
      eof_flag  <= eof_err | (eof_flag & ~rd_ext);
      disc_flag <= tenbt_disc | (disc_flag & ~rd_ext);
    end
  end

  // A disconnect always shows in the flag, even when a read clears it at once.
  a_disc_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    tenbt_disc |=> disc_flag)
    else $error("Disconnect flag not set after event.");

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic            wr_clr;
  logic            wr_en;
  logic      [1:0] evt;

  assign wr_clr = apb_wr && (paddr == PECS_ADDR_IRQ_CLR);
  assign wr_en  = apb_wr && (paddr == PECS_ADDR_IRQ_EN);
  assign evt    = {tenbt_disc, eof_err};

  // Sticky status; a new event beats a clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_stat <= PECS_RST_IRQ;
    end else begin
      irq_stat <= evt | (irq_stat & ~(wr_clr ? pwdata[1:0] : 2'b00));
    end
  end

  // Enable register and the interrupt level.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_en <= PECS_RST_IRQ;
      irq    <= 1'b0;
    end else begin
      if (wr_en) begin
        irq_en <= pwdata[1:0];
      end
      irq <= |(irq_stat & irq_en);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  a_squelch_rsvd: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_ext && !swrst && (eff_data[PECS_BIT_SQL+1:PECS_BIT_SQL] == 2'b11)
    |=> (squelch == $past(squelch)))
    else $error("Reserved squelch code was accepted.");

  a_bypass_pass: assert property (@(posedge clk_sys) disable iff (!rstn)
    bypass |=> link_pass)
    else $error("Bypass did not force link pass.");

  a_sticky_keep: assert property (@(posedge clk_sys) disable iff (!rstn)
    swrst && stky_en
    |=> (squelch == $past(squelch)) && (bcast_en == $past(bcast_en)))
    else $error("Sticky bits changed on a kept software reset.");

  a_sticky_dflt: assert property (@(posedge clk_sys) disable iff (!rstn)
    swrst && !stky_en
    |=> (squelch == PECS_RST_SQL) && (bcast_en == PECS_RST_BCAST) && sqe_dis)
    else $error("Sticky bits not defaulted on software reset.");

  a_super_stky: assert property (@(posedge clk_sys) disable iff (!rstn)
    swrst |=> $stable(stky_en))
    else $error("Software reset altered the sticky reset enable.");

  a_bcast_fwd: assert property (@(posedge clk_sys) disable iff (!rstn)
    apb_wr && is_mgmt(paddr) && bcast_en
    |=> bc_wr_valid && (bc_wr_data == $past(pwdata[15:0])))
    else $error("Write was not broadcast.");

  a_bcast_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    !bcast_en |=> !bc_wr_valid)
    else $error("Broadcast issued while disabled.");

  a_eof_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    eof_err |=> eof_flag ##1 (eof_flag || $past(rd_ext)))
    else $error("End-of-frame flag not held after event.");

  a_flag_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_ext && !eof_err && !tenbt_disc |=> !eof_flag && !disc_flag)
    else $error("Flags did not clear after read.");

endmodule // pecs_ext_ctrl

`default_nettype wire

// ==== verif/pecs_sib_phy.sv ====
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// Sibling PHY on the far side of the broadcast link
// -----------------------------------------------------------------
module pecs_sib_phy
  import pecs_pkg::*;
(
  input  wire logic        clk_sys,     // System clock.
  input  wire logic        rstn,        // Hardware reset, active low.
  input  wire logic        bc_wr_valid, // Copied write from the port.
  input  wire logic [4:0]  bc_wr_reg,   // Its register number.
  input  wire logic [15:0] bc_wr_data,  // Its data.
  output var  logic        bc_in_valid, // Write sent to the port.
  output var  logic [4:0]  bc_in_reg,   // Its register number.
  output var  logic [15:0] bc_in_data   // Its data.
);
  logic [15:0] regs [32];
  int          n_rx;

  // Every copied write lands in the same register of this sibling.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      n_rx <= 0;
    end else if (bc_wr_valid) begin
      regs[bc_wr_reg] <= bc_wr_data;
      n_rx            <= n_rx + 1;
    end
  end

  // Idle lines carry inverted values so stale data never looks valid.
  initial begin
    bc_in_valid = 1'b0;
    bc_in_reg   = 5'h1f;
    bc_in_data  = 16'hffff;
  end

  // Sends one write made while this sibling has broadcast enabled.
  task automatic send(input logic [4:0] r, input logic [15:0] d);
    @(posedge clk_sys);
    bc_in_valid <= 1'b1;
    bc_in_reg   <= r;
    bc_in_data  <= d;
    @(posedge clk_sys);
    bc_in_valid <= 1'b0;
    bc_in_reg   <= ~r;
    bc_in_data  <= ~d;
  endtask
endmodule // pecs_sib_phy

`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// Self-checking bench of the extended control and status block
// -----------------------------------------------------------------
module tb;
  import pecs_pkg::*;
  logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        lism_pass, tenbt_link, eof_err, tenbt_disc, link_pass;
  logic        sqe_off, soft_reset, irq, bc_in_valid, bc_wr_valid;
  logic [1:0]  squelch_sel;
  logic [4:0]  bc_in_reg, bc_wr_reg;
  logic [15:0] bc_in_data, bc_wr_data;
  int          n_mismatch = 0, comparisons = 0, n_srst = 0, n;

  pecs_ext_ctrl i_pecs_ext_ctrl (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .bc_in_valid, .bc_in_reg, .bc_in_data,
    .bc_wr_valid, .bc_wr_reg, .bc_wr_data, .lism_pass, .tenbt_link, .eof_err,
    .tenbt_disc, .link_pass, .squelch_sel, .sqe_off, .soft_reset, .irq);
  pecs_sib_phy i_sib (.clk_sys, .rstn, .bc_wr_valid, .bc_wr_reg, .bc_wr_data,
    .bc_in_valid, .bc_in_reg, .bc_in_data);

  // Clock of 4 ns and a counter of software reset pulses.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (soft_reset === 1'b1) n_srst <= n_srst + 1;

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer, held until pready is sampled high.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), rdata, exp);
  endtask

  // Lets registered outputs land; one event pulse of one cycle.
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic ev(input logic e);
    @(posedge clk_sys);
    if (e) eof_err <= 1'b1;
    else tenbt_disc <= 1'b1;
    @(posedge clk_sys);
    eof_err    <= 1'b0;
    tenbt_disc <= 1'b0;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog against a hang.
  initial begin
    #20000;
    n_mismatch++;
    complete_run();
  end

  // Main sequence.
  initial begin
    {psel, penable, pwrite, lism_pass, tenbt_link, eof_err, tenbt_disc, rstn} = '0;
    paddr  = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(12'h058, 32'h2200);
    chk("squelch_sel", squelch_sel, 0);
    $display("test defaults done");
    for (int i = 0; i < 3; i++) begin
      wr(12'h058, 32'h0200 | (i << 10));
      settle();
      chk("squelch_sel", squelch_sel, i);
      chk("sqe_off", sqe_off, 0);
    end
    wr(12'h058, 32'h2e00);
    settle();
    chk("squelch_sel", squelch_sel, 2);
    chk("sqe_off", sqe_off, 1);
    rd(12'h058, 32'h2a00);
    $display("test squelch done");
    wr(12'h058, 32'h8200);
    settle();
    chk("link_pass", link_pass, 1);
    wr(12'h058, 32'h0200);
    settle();
    chk("link_pass", link_pass, 0);
    @(posedge clk_sys);
    lism_pass  <= 1'b1;
    tenbt_link <= 1'b1;
    ev(1'b1);
    ev(1'b0);
    settle();
    chk("link_pass", link_pass, 1);
    rd(12'h058, 32'h03c0);
    rd(12'h058, 32'h0240);
    $display("test link and flags done");
    wr(12'h084, 32'h3);
    wr(12'h088, 32'h1);
    ev(1'b0);
    settle();
    chk("irq", irq, 0);
    rd(12'h080, 32'h2);
    ev(1'b1);
    settle();
    chk("irq", irq, 1);
    wr(12'h084, 32'h1);
    settle();
    chk("irq", irq, 0);
    wr(12'h084, 32'h2);
    rd(12'h080, 32'h0);
    rd(12'h058, 32'h03c0);
    $display("test interrupt done");
    wr(12'h058, 32'h0600);
    n = n_srst;
    wr(12'h000, 32'h8000);
    settle();
    chk("n_srst", n_srst, n + 1);
    chk("squelch_sel", squelch_sel, 1);
    wr(12'h058, 32'h0400);
    wr(12'h000, 32'h8000);
    settle();
    chk("squelch_sel", squelch_sel, 0);
    chk("sqe_off", sqe_off, 1);
    rd(12'h058, 32'h2040);
    $display("test sticky done");
    n = i_sib.n_rx;
    wr(12'h058, 32'h0201);
    wr(12'h058, 32'h0a01);
    wr(12'h000, 32'h1040);
    settle();
    chk("n_rx", i_sib.n_rx, n + 2);
    chk("sib reg22", i_sib.regs[22], 16'h0a01);
    chk("sib reg0", i_sib.regs[0], 16'h1040);
    rd(12'h058, 32'h0a41);
    wr(12'h058, 32'h0200);
    wr(12'h000, 32'h1040);
    settle();
    chk("n_rx", i_sib.n_rx, n + 3);
    i_sib.send(5'h16, 16'h0600);
    settle();
    chk("squelch_sel", squelch_sel, 1);
    $display("test broadcast done");
    xfer(1'b0, 12'h0c0, 32'h0);
    chk("pslverr", rerr, 1);
    chk("unmapped data", rdata, 0);
    rd(12'h084, 32'h0);
    $display("test unmapped done");
    complete_run();
  end
endmodule // tb

`default_nettype wire
